//--- include/ccks_cal_if.sv
// Calibration wave signals between the register bank and its wave generator
`timescale 1ns/10ps
interface ccks_cal_if;
  logic osc_tick;
  logic corr_half_tick;
  logic slow_sel;
  logic wave;
  modport gen (input osc_tick, input corr_half_tick, input slow_sel, output wave);
  modport ctl (output osc_tick, output corr_half_tick, output slow_sel, input wave);
endinterface

//--- include/ccks_pkg.sv
// Constants and types for the charger configuration and keyed function registers
package ccks_pkg;
  localparam logic [7:0] CCKS_ADDR_CHARGER_CONFIG = 8'h09;
  localparam logic [7:0] CCKS_ADDR_UNLOCK_KEY_FIRST = 8'h20;
  localparam logic [7:0] CCKS_ADDR_UNLOCK_KEY_SECOND = 8'h21;
  localparam logic [7:0] CCKS_ADDR_SPECIAL_FUNCTION = 8'h22;
  localparam logic [7:0] CCKS_RESET_CHARGER_CONFIG = 8'haa;
  localparam logic [7:0] CCKS_RESET_SPECIAL_FUNCTION = 8'h00;
  localparam logic [7:0] CCKS_KEY_READ_VALUE = 8'h00;
  localparam logic [7:0] CCKS_UNMAPPED_READ_VALUE = 8'h00;
  localparam logic [7:0] CCKS_UNLOCK_BYTE_FIRST = 8'h5e;
  localparam logic [7:0] CCKS_UNLOCK_BYTE_SECOND = 8'hc7;
  localparam int CCKS_ENABLE_CODE_LSB = 0;
  localparam int CCKS_ENABLE_CODE_W = 4;
  localparam logic [3:0] CCKS_ENABLE_CODE_ON = 4'h5;
  localparam int CCKS_BYPASS_BIT = 6;
  localparam int CCKS_SLOW_CAL_BIT = 0;
  localparam int CCKS_OSC_HZ = 32768;
  localparam int CCKS_FAST_CAL_HZ = 512;
  localparam int CCKS_FAST_HALF_TICKS = CCKS_OSC_HZ / (2 * CCKS_FAST_CAL_HZ);
  localparam int CCKS_FAST_CNT_W = $clog2(CCKS_FAST_HALF_TICKS);
  typedef enum logic [1:0] {
    CCKS_LOCKED,
    CCKS_FIRST_SEEN,
    CCKS_UNLOCKED
  } ccks_unlock_type;
endpackage

//--- rtl/ccks_bank.sv
// Charger configuration and key protected function register bank
// Operation
// - The charger is active only while the enable code field holds 0x5.
// - The bypass transistor is on when the bypass bit is 1 and off when it is 0.
// - The first key register reads 0x00 and expects 0x5E.
// - The second key register reads 0x00 and expects 0xC7.
// - The protected register is writable only after first key then second key.
// - With the slow select bit clear, as after reset, the output is 512 Hz.
// - With the slow select bit set, the output is a corrected 1 Hz wave.
// - The 512 Hz wave comes from raw oscillator ticks without ppm correction.
// - With frequency test set, the interrupt pin carries the calibration wave.
// - Trickle charging needs enable code, bypass and switch two all closed.
`timescale 1ns/10ps
module ccks_bank
  import ccks_pkg::*;
#(
  parameter int HALF_TICKS = CCKS_FAST_HALF_TICKS
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic osc_tick_i,
  input wire logic corr_half_tick_i,
  input wire logic charge_switch_two_i,
  input wire logic freq_test_select_i,
  input wire logic out_level_i,
  output logic [7:0] reg_rdata_o,
  output logic charger_active_o,
  output logic bypass_on_o,
  output logic trickle_charge_o,
  output logic cal_wave_o,
  output logic irq_o,
  output logic irq_oe_o
);
  typedef struct packed {
    ccks_unlock_type lock;
    logic [7:0] charger_config;
    logic slow_cal_select;
    logic [7:0] rdata;
    logic chg_act;
    logic bypass;
    logic trickle;
    logic wave;
    logic irq_oe;
  } ccks_bank_state_type;

  ccks_bank_state_type s_q;
  ccks_bank_state_type s_d;
  ccks_cal_if cal ();

  logic [3:0] charger_enable_code;
  logic charge_bypass_switch;
  logic wr_cfg;
  logic wr_key1;
  logic wr_key2;
  logic wr_sfr;
  logic irq_level;

  assign charger_enable_code =
    s_q.charger_config[CCKS_ENABLE_CODE_LSB +: CCKS_ENABLE_CODE_W];
  assign charge_bypass_switch = s_q.charger_config[CCKS_BYPASS_BIT];
  assign wr_cfg = reg_wr_i && reg_addr_i == CCKS_ADDR_CHARGER_CONFIG;
  assign wr_key1 = reg_wr_i && reg_addr_i == CCKS_ADDR_UNLOCK_KEY_FIRST;
  assign wr_key2 = reg_wr_i && reg_addr_i == CCKS_ADDR_UNLOCK_KEY_SECOND;
  assign wr_sfr = reg_wr_i && reg_addr_i == CCKS_ADDR_SPECIAL_FUNCTION;

  assign cal.osc_tick = osc_tick_i;
  assign cal.corr_half_tick = corr_half_tick_i;
  assign cal.slow_sel = s_q.slow_cal_select;

  ccks_cal_gen #(
    .HALF_TICKS(HALF_TICKS)
  ) u_gen (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .cal(cal)
  );

  always_comb begin
    s_d = s_q;
    irq_level = out_level_i;
    if (wr_cfg) begin
      s_d.charger_config = reg_wdata_i;
    end
    unique case (s_q.lock)
      CCKS_LOCKED: begin
        if (wr_key1 && reg_wdata_i == CCKS_UNLOCK_BYTE_FIRST) begin
          s_d.lock = CCKS_FIRST_SEEN;
        end
      end
      CCKS_FIRST_SEEN: begin
        if (wr_key2 && reg_wdata_i == CCKS_UNLOCK_BYTE_SECOND) begin
          s_d.lock = CCKS_UNLOCKED;
        end else if (wr_key1 && reg_wdata_i == CCKS_UNLOCK_BYTE_FIRST) begin
          s_d.lock = CCKS_FIRST_SEEN;
        end else if (reg_wr_i) begin
          s_d.lock = CCKS_LOCKED;
        end
      end
      CCKS_UNLOCKED: begin
        if (wr_sfr) begin
          s_d.slow_cal_select = reg_wdata_i[CCKS_SLOW_CAL_BIT];
          s_d.lock = CCKS_LOCKED;
        end else if (wr_key1 && reg_wdata_i == CCKS_UNLOCK_BYTE_FIRST) begin
          s_d.lock = CCKS_FIRST_SEEN;
        end else if (reg_wr_i) begin
          s_d.lock = CCKS_LOCKED;
        end
      end
      default: begin
        s_d.lock = CCKS_LOCKED;
      end
    endcase
    s_d.rdata = CCKS_UNMAPPED_READ_VALUE;
    if (reg_rd_i) begin
      if (reg_addr_i == CCKS_ADDR_CHARGER_CONFIG) begin
        s_d.rdata = s_q.charger_config;
      end else if (reg_addr_i == CCKS_ADDR_UNLOCK_KEY_FIRST) begin
        s_d.rdata = CCKS_KEY_READ_VALUE;
      end else if (reg_addr_i == CCKS_ADDR_UNLOCK_KEY_SECOND) begin
        s_d.rdata = CCKS_KEY_READ_VALUE;
      end else if (reg_addr_i == CCKS_ADDR_SPECIAL_FUNCTION) begin
        s_d.rdata = {7'h00, s_q.slow_cal_select};
      end
    end else begin
      s_d.rdata = s_q.rdata;
    end
    s_d.chg_act = charger_enable_code == CCKS_ENABLE_CODE_ON;
    s_d.bypass = charge_bypass_switch;
    s_d.trickle = s_d.chg_act && charge_bypass_switch && charge_switch_two_i;
    s_d.wave = cal.wave;
    if (freq_test_select_i) begin
      irq_level = cal.wave;
    end
    s_d.irq_oe = ~irq_level;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q.lock <= CCKS_LOCKED;
      s_q.charger_config <= CCKS_RESET_CHARGER_CONFIG;
      s_q.slow_cal_select <= CCKS_RESET_SPECIAL_FUNCTION[CCKS_SLOW_CAL_BIT];
      s_q.rdata <= 8'h00;
      s_q.chg_act <= 1'b0;
      s_q.bypass <= 1'b0;
      s_q.trickle <= 1'b0;
      s_q.wave <= 1'b0;
      s_q.irq_oe <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign charger_active_o = s_q.chg_act;
  assign bypass_on_o = s_q.bypass;
  assign trickle_charge_o = s_q.trickle;
  assign cal_wave_o = s_q.wave;
  assign irq_o = 1'b0;
  assign irq_oe_o = s_q.irq_oe;

  property p_charger_code;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ##1 charger_active_o == ($past(charger_enable_code) == CCKS_ENABLE_CODE_ON);
  endproperty
  a_charger_code: assert property (p_charger_code) else $error("Charger state wrong");

  property p_bypass;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_cfg ##1 1'b1 |=> bypass_on_o == $past(reg_wdata_i[CCKS_BYPASS_BIT], 2);
  endproperty
  a_bypass: assert property (p_bypass) else $error("Bypass not following bit");

  property p_key1_read;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == CCKS_ADDR_UNLOCK_KEY_FIRST |=> reg_rdata_o == 8'h00;
  endproperty
  a_key1_read: assert property (p_key1_read) else $error("First key read not zero");

  property p_key2_read;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == CCKS_ADDR_UNLOCK_KEY_SECOND |=> reg_rdata_o == 8'h00;
  endproperty
  a_key2_read: assert property (p_key2_read) else $error("Second key read not zero");

  property p_locked_write;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_sfr && s_q.lock != CCKS_UNLOCKED |=> $stable(s_q.slow_cal_select);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("Locked write took effect");

  property p_unlock_seq;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_key2 && reg_wdata_i == CCKS_UNLOCK_BYTE_SECOND && s_q.lock == CCKS_FIRST_SEEN
      |=> s_q.lock == CCKS_UNLOCKED;
  endproperty
  a_unlock_seq: assert property (p_unlock_seq) else $error("Key sequence did not unlock");

  property p_consume;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_sfr && s_q.lock == CCKS_UNLOCKED
      |=> s_q.lock == CCKS_LOCKED && s_q.slow_cal_select == $past(reg_wdata_i[0]);
  endproperty
  a_consume: assert property (p_consume) else $error("Unlock not consumed");

  property p_discard;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_cfg && s_q.lock == CCKS_FIRST_SEEN |=> s_q.lock == CCKS_LOCKED;
  endproperty
  a_discard: assert property (p_discard) else $error("Partial unlock kept");

  property p_trickle;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    trickle_charge_o == (charger_active_o && bypass_on_o && $past(charge_switch_two_i));
  endproperty
  a_trickle: assert property (p_trickle) else $error("Trickle without all switches");

  property p_irq_test;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    freq_test_select_i |=> irq_oe_o == !$past(cal.wave);
  endproperty
  a_irq_test: assert property (p_irq_test) else $error("Interrupt pin not carrying wave");
endmodule

//--- rtl/ccks_cal_gen.sv
// Calibration square wave generator, 512 Hz raw or 1 Hz corrected
`timescale 1ns/10ps
module ccks_cal_gen
  import ccks_pkg::*;
#(
  parameter int HALF_TICKS = CCKS_FAST_HALF_TICKS
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  ccks_cal_if.gen cal
);
  localparam int CW = $clog2(HALF_TICKS);
  localparam logic [CW-1:0] LAST = CW'(HALF_TICKS - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic wave;
  } ccks_gen_state_type;

  ccks_gen_state_type s_q;
  ccks_gen_state_type s_d;

  always_comb begin
    s_d = s_q;
    if (cal.slow_sel) begin
      s_d.cnt = '0;
      if (cal.corr_half_tick) begin
        s_d.wave = ~s_q.wave;
      end
    end else if (cal.osc_tick) begin
      if (s_q.cnt == LAST) begin
        s_d.cnt = '0;
        s_d.wave = ~s_q.wave;
      end else begin
        s_d.cnt = s_q.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cal.wave = s_q.wave;

  property p_slow_toggle;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cal.slow_sel && cal.corr_half_tick |=> cal.wave != $past(cal.wave);
  endproperty
  a_slow_toggle: assert property (p_slow_toggle) else $error("Slow wave missed tick");

  property p_fast_toggle;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !cal.slow_sel && cal.osc_tick && s_q.cnt == LAST |=> cal.wave != $past(cal.wave);
  endproperty
  a_fast_toggle: assert property (p_fast_toggle) else $error("Fast wave missed toggle");

  property p_fast_raw;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !cal.slow_sel && !cal.osc_tick |=> $stable(cal.wave);
  endproperty
  a_fast_raw: assert property (p_fast_raw) else $error("Fast wave moved without tick");
endmodule

//--- sim/ccks_host.sv
// Host model driving the byte register strobe port of the bank
`timescale 1ns/10ps
module ccks_host
  import ccks_pkg::*;
(
  input wire logic ref_clk_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'hff;
    reg_wdata_o = 8'h00;
  end

  // One byte transfer; address and data are scrambled once released
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    reg_wr_o = wr;
    reg_rd_o = ~wr;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(negedge ref_clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
    @(negedge ref_clk_i);
  endtask

  task automatic unlock();
    xfer(1'b1, CCKS_ADDR_UNLOCK_KEY_FIRST, CCKS_UNLOCK_BYTE_FIRST);
    xfer(1'b1, CCKS_ADDR_UNLOCK_KEY_SECOND, CCKS_UNLOCK_BYTE_SECOND);
  endtask

  // Keyed write with reserved bits zero
  task automatic wr_sfr(input logic v);
    unlock();
    xfer(1'b1, CCKS_ADDR_SPECIAL_FUNCTION, {7'h00, v});
  endtask
endmodule

//--- sim/tb.sv
// Self-checking bench for the charger and keyed function register bank
`timescale 1ns/10ps
module tb;
  import ccks_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr, reg_rd, act, byp, trk, wave, irq, irq_oe, last;
  logic osc_tick = 1'b0, corr_tick = 1'b0, sw_two = 1'b0, ft = 1'b1, out_lvl = 1'b1;
  logic rd_d1 = 1'b0, rd_d2 = 1'b0;
  logic [7:0] addr, wdata, rdata, cfg;
  logic [7:0] exp_q[$];
  int fails = 0, comparisons = 0, cyc = 0, tog;

  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  ccks_host u_host (.ref_clk_i(ref_clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata));
  ccks_bank #(.HALF_TICKS(2)) u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .osc_tick_i(osc_tick), .corr_half_tick_i(corr_tick), .charge_switch_two_i(sw_two),
    .freq_test_select_i(ft), .out_level_i(out_lvl), .reg_rdata_o(rdata),
    .charger_active_o(act), .bypass_on_o(byp), .trickle_charge_o(trk),
    .cal_wave_o(wave), .irq_o(irq), .irq_oe_o(irq_oe));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d);
  endtask

  // Counts wave toggles over 16 raw ticks and 4 corrected half ticks
  task automatic wave_run(input logic [7:0] exp);
    tog = 0;
    @(negedge ref_clk_i);
    last = wave;
    for (int i = 0; i < 64; i++) begin
      osc_tick = (i % 4 == 0);
      corr_tick = (i % 16 == 2);
      @(negedge ref_clk_i);
      if (wave !== last) begin
        tog++;
      end
      last = wave;
      chk(8'(irq_oe), 8'(!wave), "pin shows wave");
    end
    osc_tick = 1'b0;
    corr_tick = 1'b0;
    chk(8'(irq), 8'h00, "pin data");
    chk(8'(tog), exp, "wave toggles");
  endtask

  always @(posedge ref_clk_i) begin
    rd_d1 <= reg_rd;
    rd_d2 <= rd_d1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // Read data monitor against the noted expectations
  always @(negedge ref_clk_i) begin
    if (rd_d2 && exp_q.size() > 0) begin
      chk(rdata, exp_q.pop_front(), "read data");
    end
  end

  initial begin
    void'($urandom(9));
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    rd(CCKS_ADDR_CHARGER_CONFIG, CCKS_RESET_CHARGER_CONFIG);
    rd(CCKS_ADDR_SPECIAL_FUNCTION, CCKS_RESET_SPECIAL_FUNCTION);
    rd(8'h30, CCKS_UNMAPPED_READ_VALUE);
    chk(8'(act), 8'h00, "reset charger");
    wave_run(8'h08);
    $display("test reset and fast wave done");
    for (int i = 0; i < 12; i++) begin
      cfg = (i < 2) ? {1'b0, i[0], 6'h05} : (8'($urandom) & 8'h4f);
      sw_two = 1'($urandom);
      wr(CCKS_ADDR_CHARGER_CONFIG, cfg);
      repeat (2) @(negedge ref_clk_i);
      chk(8'(act), 8'(cfg[3:0] == 4'h5), "charger active");
      chk(8'(byp), 8'(cfg[6]), "bypass");
      chk(8'(trk), 8'(cfg[3:0] == 4'h5 && cfg[6] && sw_two), "trickle");
      rd(CCKS_ADDR_CHARGER_CONFIG, cfg);
    end
    $display("test charger done");
    rd(CCKS_ADDR_UNLOCK_KEY_FIRST, 8'h00);
    rd(CCKS_ADDR_UNLOCK_KEY_SECOND, 8'h00);
    wr(CCKS_ADDR_SPECIAL_FUNCTION, 8'h01);
    rd(CCKS_ADDR_SPECIAL_FUNCTION, 8'h00);
    wr(CCKS_ADDR_UNLOCK_KEY_SECOND, CCKS_UNLOCK_BYTE_SECOND);
    wr(CCKS_ADDR_UNLOCK_KEY_FIRST, CCKS_UNLOCK_BYTE_FIRST);
    wr(CCKS_ADDR_SPECIAL_FUNCTION, 8'h01);
    rd(CCKS_ADDR_SPECIAL_FUNCTION, 8'h00);
    wr(CCKS_ADDR_UNLOCK_KEY_FIRST, CCKS_UNLOCK_BYTE_FIRST);
    wr(CCKS_ADDR_CHARGER_CONFIG, cfg);
    wr(CCKS_ADDR_UNLOCK_KEY_SECOND, CCKS_UNLOCK_BYTE_SECOND);
    wr(CCKS_ADDR_SPECIAL_FUNCTION, 8'h01);
    rd(CCKS_ADDR_SPECIAL_FUNCTION, 8'h00);
    u_host.wr_sfr(1'b1);
    rd(CCKS_ADDR_SPECIAL_FUNCTION, 8'h01);
    wr(CCKS_ADDR_SPECIAL_FUNCTION, 8'h00);
    rd(CCKS_ADDR_SPECIAL_FUNCTION, 8'h01);
    $display("test unlock done");
    wave_run(8'h04);
    ft = 1'b0;
    for (int i = 0; i < 6; i++) begin
      out_lvl = 1'($urandom);
      repeat (3) @(negedge ref_clk_i);
      chk(8'(irq_oe), 8'(!out_lvl), "pin level");
    end
    $display("test slow wave and pin done");
    end_of_test();
  end
endmodule
